// file: aea_params.svh
// Purpose: Constants for the active energy accumulator
// Assumes: 40 MHz aclk, 8 kHz power sample rate
// Notes:   Register offsets are byte addresses on AXI4-Lite
`ifndef AEA_PARAMS_SVH
`define AEA_PARAMS_SVH

// Clock and sample timing
`define AEA_CLK_MHZ        40
`define AEA_SAMPLE_US      125

// Register byte offsets
`define AEA_OFS_GAIN       8'h00
`define AEA_OFS_OFFSET     8'h18
`define AEA_OFS_THR_LO     8'h30
`define AEA_OFS_THR_HI     8'h34
`define AEA_OFS_ACCUM_MODE 8'h38
`define AEA_OFS_FIRST_STATUS_REGISTER    8'h3C
`define AEA_OFS_FIRST_MASK_REGISTER      8'h40
`define AEA_OFS_SIGN_FLAGS 8'h44
`define AEA_OFS_ENERGY     8'h48
`define AEA_ADDR_STEP      8'h04

// Field positions
`define AEA_SRC_SEL_BIT    6
`define AEA_SCHG_LSB       6
`define AEA_SCHG_MSB       8
`define AEA_GAIN_FRAC      23

// Reset values
`define AEA_THR_RESET      48'h0000_01FF_6A6B
`define AEA_GAIN_RESET     24'h00_0000
`define AEA_OFFSET_RESET   24'h00_0000

// AXI responses
`define AEA_RESP_OKAY      2'h0
`define AEA_RESP_SLVERR    2'h2

`endif

// file: aea_pkg.sv
// Purpose: Types for the active energy accumulator
// Assumes: Power words are signed 28-bit values at the sample rate
// Notes:   Channel order is total A,B,C then fundamental A,B,C
package aea_pkg;
   typedef logic signed [27:0] aea_word_t;
   typedef struct packed {
      aea_word_t [2:0] fund;
      aea_word_t [2:0] total;
   } aea_pwr_s;
   localparam int AEA_NCH = 6;
endpackage

// file: aea_core.sv
// Purpose: Per-phase power trim, sign detection, two-stage energy accumulation
// Assumes: Power words arrive on aclk, held valid across each sample tick
// Notes:   Registers on AXI4-Lite, one write and one read outstanding
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "aea_params.svh"

module aea_core
   import aea_pkg::*;
#(
   parameter int SAMPLE_CYCLES = `AEA_SAMPLE_US * `AEA_CLK_MHZ
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire aea_pwr_s    pwr,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [5:0]       energy_pulse,
   output logic [5:0]       energy_pulse_neg,
   output logic             primary_interrupt_line_n
);

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Low three byte lanes of a write merged into a 24-bit field
   function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = merge({8'h00, old}, d, be);
      return r[23:0];
   endfunction

   // Signed 24-bit value shown as a 28-bit sign-extended word
   function automatic logic [31:0] rd24(input logic [23:0] v);
      return {4'h0, {4{v[23]}}, v};
   endfunction

   // Address of slot i in a bank of six words
   function automatic logic [7:0] slot(input logic [7:0] base, input int i);
      return base + 8'(i) * `AEA_ADDR_STEP;
   endfunction

   logic [15:0]            tick_cnt_r;
   logic                   tick_r;
   logic [23:0]            gain_r [AEA_NCH];
   logic [23:0]            ofs_r [AEA_NCH];
   logic [47:0]            thr_r;
   logic                   src_sel_r;
   logic [2:0]             schg_r;
   logic [2:0]             mask_r;
   logic [2:0]             sign_flags_r;
   logic signed [49:0]     acc_r [AEA_NCH];
   logic signed [31:0]     cnt_r [AEA_NCH];
   logic [AEA_NCH-1:0]     chsign_r;
   logic [AEA_NCH-1:0]     fire_pos;
   logic [AEA_NCH-1:0]     fire_neg;
   logic signed [49:0]     acc_nxt [AEA_NCH];
   logic                   aw_hold_r;
   logic                   w_hold_r;
   logic [7:0]             waddr_r;
   logic [31:0]            wdata_r;
   logic [3:0]             wstrb_r;
   logic                   wr_do;
   logic                   wr_hit;
   logic [31:0]            rd_word;
   logic                   rd_hit;
   logic                   ar_take;
   logic [31:0]            st_merged;
   logic [31:0]            mode_merged;
   logic [31:0]            mask_merged;

   // Sample-rate enable divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 16'(SAMPLE_CYCLES - 1)) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r     <= 1'b0;
      end
   end

   // Per-channel trim and first-stage accumulation
   genvar g;
   generate
      for (g = 0; g < AEA_NCH; g++) begin : g_ch
         aea_word_t          p;
         aea_word_t          gain_x;
         logic signed [55:0] prod;
         logic signed [33:0] trimmed;
         logic signed [49:0] sum;
         logic signed [49:0] thr_s;
         if (g < 3) begin : g_tot
            assign p = pwr.total[g];
         end else begin : g_fnd
            assign p = pwr.fund[g-3];
         end
         assign gain_x  = aea_word_t'($signed(gain_r[g]));
         assign prod    = p * gain_x;
         // Power times (1 + gain/2^23), then offset
         assign trimmed = 34'(p) + 34'(prod >>> `AEA_GAIN_FRAC)
                        + 34'($signed(ofs_r[g]));
         assign thr_s   = $signed({2'h0, thr_r});
         assign sum     = acc_r[g] + 50'(trimmed);
         always_comb begin
            fire_pos[g] = 1'b0;
            fire_neg[g] = 1'b0;
            acc_nxt[g]  = sum;
            if (sum >= thr_s) begin
               fire_pos[g] = 1'b1;
               acc_nxt[g]  = sum - thr_s;
            end else if (sum <= -thr_s) begin
               fire_neg[g] = 1'b1;
               acc_nxt[g]  = sum + thr_s;
            end
         end
      end
   endgenerate

   // First stage state, pulses and second-stage counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         energy_pulse     <= 6'h00;
         energy_pulse_neg <= 6'h00;
         chsign_r         <= 6'h00;
         for (int i = 0; i < AEA_NCH; i++) begin
            acc_r[i] <= 50'sh0;
            cnt_r[i] <= 32'sh0;
         end
      end else begin
         energy_pulse     <= 6'h00;
         energy_pulse_neg <= 6'h00;
         if (tick_r) begin
            for (int i = 0; i < AEA_NCH; i++) begin
               acc_r[i] <= acc_nxt[i];
               if (fire_pos[i] || fire_neg[i]) begin
                  energy_pulse[i]     <= 1'b1;
                  energy_pulse_neg[i] <= fire_neg[i];
                  chsign_r[i]         <= fire_neg[i];
                  if (fire_neg[i]) begin
                     cnt_r[i] <= cnt_r[i] - 32'sh1;
                  end else begin
                     cnt_r[i] <= cnt_r[i] + 32'sh1;
                  end
               end
            end
         end
      end
   end

   // Sign change detection on the selected power, status and sign flags
   assign st_merged = merge(32'h0, wdata_r, wstrb_r);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         schg_r       <= 3'h0;
         sign_flags_r <= 3'h0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            // Write one clears; a set in the same cycle wins
            if (wr_do && waddr_r == `AEA_OFS_FIRST_STATUS_REGISTER
                && st_merged[`AEA_SCHG_LSB + k]) begin
               schg_r[k] <= 1'b0;
            end
            if (tick_r) begin
               if (src_sel_r) begin
                  if ((fire_pos[k+3] || fire_neg[k+3])
                      && fire_neg[k+3] != chsign_r[k+3]) begin
                     schg_r[k]       <= 1'b1;
                     sign_flags_r[k] <= fire_neg[k+3];
                  end
               end else begin
                  if ((fire_pos[k] || fire_neg[k])
                      && fire_neg[k] != chsign_r[k]) begin
                     schg_r[k]       <= 1'b1;
                     sign_flags_r[k] <= fire_neg[k];
                  end
               end
            end
         end
      end
   end

   // Interrupt line, low while any enabled sign change is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         primary_interrupt_line_n <= 1'b1;
      end else begin
         primary_interrupt_line_n <= ~|(schg_r & mask_r);
      end
   end

   // Write address and data capture, either order
   assign wr_do = aw_hold_r && w_hold_r && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AEA_RESP_OKAY;
         waddr_r       <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r     <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_r       <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r     <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
         end
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AEA_RESP_OKAY : `AEA_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Any register address, read-only ones included
   always_comb begin
      wr_hit = waddr_r <= `AEA_OFS_SIGN_FLAGS
            || (waddr_r >= `AEA_OFS_ENERGY && waddr_r <= slot(`AEA_OFS_ENERGY, 5));
   end

   // Mode bit and three-bit mask field merged in place, other bits kept at zero
   assign mode_merged = merge({25'h0, src_sel_r, 6'h00}, wdata_r, wstrb_r);
   assign mask_merged = merge({23'h0, mask_r, 6'h00}, wdata_r, wstrb_r);

   // Software-written configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thr_r     <= `AEA_THR_RESET;
         src_sel_r <= 1'b0;
         mask_r    <= 3'h0;
         for (int i = 0; i < AEA_NCH; i++) begin
            gain_r[i] <= `AEA_GAIN_RESET;
            ofs_r[i]  <= `AEA_OFFSET_RESET;
         end
      end else if (wr_do) begin
         for (int i = 0; i < AEA_NCH; i++) begin
            if (waddr_r == slot(`AEA_OFS_GAIN, i)) begin
               gain_r[i] <= merge24(gain_r[i], wdata_r, wstrb_r);
            end
            if (waddr_r == slot(`AEA_OFS_OFFSET, i)) begin
               ofs_r[i] <= merge24(ofs_r[i], wdata_r, wstrb_r);
            end
         end
         case (waddr_r)
            `AEA_OFS_THR_LO: begin
               thr_r[23:0] <= merge24(thr_r[23:0], wdata_r, wstrb_r);
            end
            `AEA_OFS_THR_HI: begin
               thr_r[47:24] <= merge24(thr_r[47:24], wdata_r, wstrb_r);
            end
            `AEA_OFS_ACCUM_MODE: begin
               src_sel_r <= mode_merged[`AEA_SRC_SEL_BIT];
            end
            `AEA_OFS_FIRST_MASK_REGISTER: begin
               mask_r <= mask_merged[`AEA_SCHG_MSB:`AEA_SCHG_LSB];
            end
            default: begin
               mask_r <= mask_r;
            end
         endcase
      end
   end

   // Read decode; energy words are the live counters copied at access
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      for (int i = 0; i < AEA_NCH; i++) begin
         if ({s_axi_araddr[7:2], 2'h0} == slot(`AEA_OFS_GAIN, i)) begin
            rd_word = rd24(gain_r[i]);
         end
         if ({s_axi_araddr[7:2], 2'h0} == slot(`AEA_OFS_OFFSET, i)) begin
            rd_word = rd24(ofs_r[i]);
         end
         if ({s_axi_araddr[7:2], 2'h0} == slot(`AEA_OFS_ENERGY, i)) begin
            rd_word = cnt_r[i];
         end
      end
      case ({s_axi_araddr[7:2], 2'h0})
         `AEA_OFS_THR_LO: begin
            rd_word = {8'h00, thr_r[23:0]};
         end
         `AEA_OFS_THR_HI: begin
            rd_word = {8'h00, thr_r[47:24]};
         end
         `AEA_OFS_ACCUM_MODE: begin
            rd_word[`AEA_SRC_SEL_BIT] = src_sel_r;
         end
         `AEA_OFS_FIRST_STATUS_REGISTER: begin
            rd_word[`AEA_SCHG_MSB:`AEA_SCHG_LSB] = schg_r;
         end
         `AEA_OFS_FIRST_MASK_REGISTER: begin
            rd_word[`AEA_SCHG_MSB:`AEA_SCHG_LSB] = mask_r;
         end
         `AEA_OFS_SIGN_FLAGS: begin
            rd_word[2:0] = sign_flags_r;
         end
         default: begin
            if ({s_axi_araddr[7:2], 2'h0} > slot(`AEA_OFS_ENERGY, 5)) begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   // Read channel, one outstanding read
   assign ar_take = s_axi_arvalid && s_axi_arready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `AEA_RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `AEA_RESP_OKAY : `AEA_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// file: aea_assertions.sv
// Purpose: Concurrent checks on the accumulator bus handshakes and outputs
// Assumes: One aclk domain, synchronous active-low aresetn
// Notes:   Bound to aea_core, sees only its ports
`timescale 1ns/100ps

module aea_assertions
#(
   parameter int SAMPLE_CYCLES = 5000
)(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [5:0]  energy_pulse,
   input wire logic [5:0]  energy_pulse_neg,
   input wire logic        primary_interrupt_line_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Write answer within two cycles of the joint handshake
   property p_write_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("write response late");

   // Response held until taken
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");

   // Busy for writes once address is taken
   property p_aw_busy;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_busy: assert property (p_aw_busy) else $error("second write accepted");

   // Read data one cycle after address
   property p_read_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read data late");

   // Read data held until taken
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");

   // Unmapped read gives error and zero
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h5C
         |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

   // Energy pulse lasts one cycle
   property p_pulse_one;
      |energy_pulse |=> !(|energy_pulse);
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");

   // Negative flag only with a pulse
   property p_neg_with_pulse;
      (energy_pulse_neg & ~energy_pulse) == 6'h00;
   endproperty
   a_neg_with_pulse: assert property (p_neg_with_pulse) else $error("stray negative flag");

   // Interrupt falls only after a pulse or a register write
   property p_irq_fall;
      $fell(primary_interrupt_line_n) |-> $past(|energy_pulse, 1) || $past(|energy_pulse, 2)
         || $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt without cause");

   // Interrupt released only after a register write
   property p_irq_rise;
      $rose(primary_interrupt_line_n) |-> $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2)
         || $past(s_axi_bvalid, 3);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt released alone");

   // Main scenarios reached
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_neg: cover property (|energy_pulse_neg);
   c_irq: cover property ($fell(primary_interrupt_line_n));
endmodule

bind aea_core aea_assertions #(
   .SAMPLE_CYCLES (SAMPLE_CYCLES)
) u_aea_assertions (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .energy_pulse(energy_pulse),
   .energy_pulse_neg(energy_pulse_neg), .primary_interrupt_line_n(primary_interrupt_line_n)
);

// file: tb_active_energy_accumulator.sv
// Purpose: Self-checking bench for the active energy accumulator
// Assumes: Short sample period, bench acts as AXI4-Lite master
// Notes:   Power held for whole multiples of the sample period
`timescale 1ns/100ps

module tb_active_energy_accumulator;
   import aea_pkg::*;
   localparam int SC = 8;
   logic        aclk;
   logic        aresetn;
   aea_pwr_s    pwr;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, primary_interrupt_line_n;
   logic [5:0]  energy_pulse, energy_pulse_neg;
   int          num_errors, comparisons, cyc;
   int          pulse_cnt, neg_cnt;

   aea_core #(.SAMPLE_CYCLES(SC)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .pwr(pwr), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .energy_pulse(energy_pulse),
      .energy_pulse_neg(energy_pulse_neg), .primary_interrupt_line_n(primary_interrupt_line_n)
   );

   // Clock and cycle count
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;

   // Pulse counters for total A and negative fundamental B
   always @(posedge aclk) begin
      if (energy_pulse[0])
         pulse_cnt <= pulse_cnt + 1;
      if (energy_pulse_neg[4])
         neg_cnt <= neg_cnt + 1;
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Write with one stall cycle on the response
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_p, w_p, dn;
      aw_p = 1'b1; w_p = 1'b1; dn = 1'b0;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      while (!dn) begin
         @(posedge aclk);
         if (s_axi_bvalid && s_axi_bready) begin
            dn = 1'b1;
            check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            s_axi_bready <= 1'b0;
         end else if (s_axi_bvalid)
            s_axi_bready <= 1'b1;
         if (aw_p && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
   endtask

   // Read with one stall cycle, then compare data and response
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      logic ar_p, dn;
      ar_p = 1'b1; dn = 1'b0;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      while (!dn) begin
         @(posedge aclk);
         if (s_axi_rvalid && s_axi_rready) begin
            dn = 1'b1;
            check(nm, s_axi_rdata, ed);
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            s_axi_rready <= 1'b0;
         end else if (s_axi_rvalid)
            s_axi_rready <= 1'b1;
         if (ar_p && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            ar_p = 1'b0;
         end
      end
   endtask

   task automatic do_reset(input logic [31:0] thr);
      aresetn <= 1'b0; pwr <= '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      wr(8'h30, thr, 2'h0);
      wr(8'h34, 32'h00000000, 2'h0);
   endtask

   // Hold the driven power for n cycles, then idle
   task automatic hold_pwr(input int n);
      repeat (n) @(posedge aclk);
      pwr <= '0;
      repeat (3) @(posedge aclk);
   endtask

   task automatic t_regs;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk("thr_lo", 8'h30, 32'h00FF6A6B, 2'h0);
      rd_chk("thr_hi", 8'h34, 32'h00000001, 2'h0);
      rd_chk("mode", 8'h38, 32'h00000000, 2'h0);
      wr(8'h00, 32'hFFC00000, 2'h0);
      rd_chk("gain_ta", 8'h00, 32'h0FC00000, 2'h0);
      wr(8'h34, 32'hAB000012, 2'h0);
      rd_chk("thr_hi_w", 8'h34, 32'h00000012, 2'h0);
      wr(8'h44, 32'h00000007, 2'h0);
      rd_chk("sign_ro", 8'h44, 32'h00000000, 2'h0);
      wr(8'h5C, 32'h00000005, 2'h0);
      rd_chk("energy_ro", 8'h5C, 32'h00000000, 2'h0);
      wr(8'h60, 32'h00000001, 2'h2);
      rd_chk("unmapped", 8'h60, 32'h00000000, 2'h2);
      $display("test regs done");
   endtask

   // Per-sample power never above the threshold: at most one pulse a sample
   task automatic t_energy;
      int p0, n0;
      do_reset(32'h00000080);
      wr(8'h04, 32'h00C00000, 2'h0);
      wr(8'h08, 32'h00400000, 2'h0);
      p0 = pulse_cnt;
      n0 = neg_cnt;
      pwr.total[0] <= 28'h0000080;
      pwr.total[1] <= 28'h0000080;
      pwr.total[2] <= 28'h0000040;
      pwr.fund[0] <= 28'h0000080;
      pwr.fund[1] <= 28'hFFFFF80;
      hold_pwr(12 * SC);
      check("pulses_ta", pulse_cnt - p0, 32'h0000000C);
      check("negs_fb", neg_cnt - n0, 32'h0000000C);
      rd_chk("en_ta", 8'h48, 32'h0000000C, 2'h0);
      rd_chk("en_tb", 8'h4C, 32'h00000006, 2'h0);
      rd_chk("en_tc", 8'h50, 32'h00000009, 2'h0);
      rd_chk("en_fa", 8'h54, 32'h0000000C, 2'h0);
      rd_chk("en_fb", 8'h58, 32'hFFFFFFF4, 2'h0);
      rd_chk("en_fc", 8'h5C, 32'h00000000, 2'h0);
      rd_chk("st_none", 8'h3C, 32'h00000000, 2'h0);
      $display("test energy done");
   endtask

   // Offset alone active for exactly 32 samples
   task automatic t_offset;
      int t0;
      do_reset(32'h00000040);
      t0 = cyc;
      wr(8'h24, 32'hFF000010, 2'h0);
      rd_chk("ofs_fa", 8'h24, 32'h00000010, 2'h0);
      while (cyc < t0 + 32 * SC)
         @(posedge aclk);
      wr(8'h24, 32'h00000000, 2'h0);
      rd_chk("en_ofs", 8'h54, 32'h00000008, 2'h0);
      $display("test offset done");
   endtask

   task automatic t_sign;
      do_reset(32'h00000040);
      wr(8'h40, 32'h000001C0, 2'h0);
      pwr.total[1] <= 28'h0000040;
      hold_pwr(3 * SC);
      rd_chk("st_pos", 8'h3C, 32'h00000000, 2'h0);
      pwr.total[1] <= 28'hFFFFFC0;
      hold_pwr(3 * SC);
      check("irq_low", {31'h0, primary_interrupt_line_n}, 32'h00000000);
      rd_chk("st_tb", 8'h3C, 32'h00000080, 2'h0);
      rd_chk("sg_tb", 8'h44, 32'h00000002, 2'h0);
      wr(8'h3C, 32'h00000080, 2'h0);
      repeat (3) @(posedge aclk);
      check("irq_high", {31'h0, primary_interrupt_line_n}, 32'h00000001);
      rd_chk("st_clr", 8'h3C, 32'h00000000, 2'h0);
      wr(8'h38, 32'h00000040, 2'h0);
      pwr.total[2] <= 28'hFFFFFC0;
      pwr.fund[0] <= 28'hFFFFFC0;
      hold_pwr(3 * SC);
      rd_chk("st_fa", 8'h3C, 32'h00000040, 2'h0);
      rd_chk("sg_fa", 8'h44, 32'h00000003, 2'h0);
      wr(8'h3C, 32'h00000040, 2'h0);
      wr(8'h40, 32'h00000000, 2'h0);
      pwr.fund[0] <= 28'h0000040;
      hold_pwr(3 * SC);
      check("irq_masked", {31'h0, primary_interrupt_line_n}, 32'h00000001);
      rd_chk("st_fa2", 8'h3C, 32'h00000040, 2'h0);
      rd_chk("sg_fa2", 8'h44, 32'h00000002, 2'h0);
      $display("test sign done");
   endtask

   // Hang guard
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      summarize();
   end

   initial begin
      aclk = 1'b0; aresetn = 1'b0; pwr = '0; cyc = 0;
      num_errors = 0; comparisons = 0;
      pulse_cnt = 0;
      neg_cnt = 0;
      s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
      t_regs();
      t_energy();
      t_offset();
      t_sign();
      summarize();
   end
endmodule
